// ===== verilog/eag_top.sv
// eag_top.sv: effective address generation, default segment, io port address, bus split
// assumes the decoder presents a request for one cycle with req_valid; operands stable that cycle
//
// Behaviour
// - displacement of 8, 16 or 32 bits, sign extended
// - index multiplied by scale 1, 2, 4 or 8
// - address is signed sum of components; scale unsigned
// - stack pointer never taken as index
// - stack or frame base as base gives stack segment, else data
// - components optional; scale only with index present
// - 64-bit mode uses full 64-bit base and index, sixteen registers
// - instr_pointer plus sign-extended 32-bit displacement in 64-bit mode
// - 65,536 byte ports, adjacent ones grouped as 16 or 32 bits
// - port address from immediate or 16-bit port index register
// - sizes byte, word, doubleword, quadword, double quadword
// - little-endian; lowest byte address is operand address
// - any alignment allowed; unaligned done as two accesses; code splits only memory accesses that cross their 4, 8 or 16 byte chunk
// - crossing 4-byte or 8-byte boundary detected, two bus cycles; io accesses are issued as one cycle even when they cross
// - natural: even words, by four dwords, by eight qwords
// - strict double quadword not divisible by 16 faults
// - non-strict double quadword unaligned accepted with extra cycles
// - 64-bit mode segment bases zero; linear equals effective
`timescale 1ns/1ps
`default_nettype none
`include "eag_map.svh"
module eag_top
  import eag_pkg::*;
#(
  parameter int ADDR_W = 64,
  parameter int NREG   = 16
)(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // request from decoder
  input  wire logic        req_valid,
  input  wire logic        req_is_io,
  input  wire logic        req_ip_rel,
  input  wire logic        req_strict,
  input  wire logic [1:0]  addr_size,
  input  wire eag_size_t   op_size,
  input  wire logic        base_en,
  input  wire logic [3:0]  base_sel,
  input  wire logic        index_en,
  input  wire logic [3:0]  index_sel,
  input  wire logic [1:0]  scale,
  input  wire logic [1:0]  disp_width,
  input  wire logic [31:0] disp,
  input  wire logic        seg_ovr_en,
  input  wire eag_seg_t    seg_ovr,
  input  wire logic        io_use_imm,
  input  wire logic [7:0]  io_imm,
  // register values from the register file
  input  wire logic [63:0] base_val,
  input  wire logic [63:0] index_val,
  input  wire logic [63:0] instr_pointer,
  input  wire logic [15:0] port_index_reg,
  input  wire logic [63:0] seg_base,
  // access path
  input  wire logic        acc_ready,
  output logic             busy,
  output logic             acc_valid,
  output logic [63:0]      acc_addr,
  output logic [4:0]       acc_bytes,
  output logic             acc_io,
  output logic             acc_last,
  output eag_seg_t         acc_seg,
  output logic [63:0]      eff_addr,
  output logic             general_protection_fault
);
  // ==========================================================
  // parameter check
  if (ADDR_W != 64 || NREG != 16) begin : g_chk
    $error("eag_top supports only 64-bit addresses and sixteen registers");
  end

  function automatic logic [63:0] trunc_as(input logic [63:0] v, input logic [1:0] as);
    trunc_as = (as == `EAG_AS_16) ? {48'h0, v[15:0]} :
               (as == `EAG_AS_32) ? {32'h0, v[31:0]} : v;
  endfunction

  // ==========================================================
  // effective address
  wire [63:0] disp_x = (disp_width == `EAG_DW_8)  ? {{56{disp[7]}}, disp[7:0]} :
                       (disp_width == `EAG_DW_16) ? {{48{disp[15]}}, disp[15:0]} :
                       (disp_width == `EAG_DW_32) ? {{32{disp[31]}}, disp} : 64'h0;
  wire        idx_ok = index_en && (index_sel != `EAG_REG_STACK_PTR);
  wire [63:0] idx_x  = idx_ok ? (index_val << scale) : 64'h0;
  wire [63:0] base_x = base_en ? base_val : 64'h0;
  wire        ipr_w  = req_ip_rel && (addr_size == `EAG_AS_64);
  wire [63:0] ipr_x  = {{32{disp[31]}}, disp};
  wire [63:0] sum_w  = ipr_w ? (instr_pointer + ipr_x) : (base_x + idx_x + disp_x);
  wire [63:0] ea_w   = trunc_as(sum_w, addr_size);
  wire        stk_w  = base_en && !ipr_w &&
                       (base_sel == `EAG_REG_STACK_PTR || base_sel == `EAG_REG_FRAME_BASE);
  wire [1:0]  seg_w  = seg_ovr_en ? seg_ovr : (stk_w ? `EAG_SEG_STACK : `EAG_SEG_DATA);
  wire [63:0] lin_w  = (addr_size == `EAG_AS_64) ? ea_w : (ea_w + seg_base);
  wire [63:0] port_w = io_use_imm ? {56'h0, io_imm} : {48'h0, port_index_reg};
  wire [63:0] addr_w = req_is_io ? port_w : lin_w;

  // ==========================================================
  // alignment
  logic       split_w;
  logic       fault_w;
  logic [4:0] flen_w;
  eag_align u_align (
    .addr_lo   (addr_w[3:0]),
    .size      (op_size),
    .strict    (req_strict && !req_is_io),
    .split     (split_w),
    .fault     (fault_w),
    .first_len (flen_w)
  );
  wire [4:0] nbytes_w = 5'(1) << op_size;
  wire       split_m  = split_w && !req_is_io;

  // ==========================================================
  // bus sequencing
  eag_state_t st_r, st_nxt;
  logic [63:0] sec_addr_r;
  logic [4:0]  sec_bytes_r;
  wire take_w = req_valid && (st_r == EAG_ST_IDLE);
  wire done_w = acc_valid && acc_ready;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      EAG_ST_IDLE:  if (take_w && !fault_w) st_nxt = EAG_ST_FIRST;
      EAG_ST_FIRST: if (done_w) st_nxt = acc_last ? EAG_ST_IDLE : EAG_ST_SECND;
      EAG_ST_SECND: if (done_w) st_nxt = EAG_ST_IDLE;
      default:      st_nxt = EAG_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r                     <= EAG_ST_IDLE;
      acc_valid                <= 1'b0;
      acc_addr                 <= 64'h0;
      acc_bytes                <= 5'h0;
      acc_io                   <= 1'b0;
      acc_last                 <= 1'b0;
      acc_seg                  <= `EAG_SEG_DATA;
      eff_addr                 <= 64'h0;
      general_protection_fault <= 1'b0;
      busy                     <= 1'b0;
      sec_addr_r               <= 64'h0;
      sec_bytes_r              <= 5'h0;
    end else begin
      st_r                     <= st_nxt;
      busy                     <= (st_nxt != EAG_ST_IDLE);
      general_protection_fault <= take_w && fault_w;
      if (take_w) begin
        eff_addr <= req_is_io ? port_w : ea_w;
        acc_seg  <= seg_w;
      end
      if (take_w && !fault_w) begin
        acc_valid   <= 1'b1;
        acc_addr    <= addr_w;
        acc_io      <= req_is_io;
        acc_bytes   <= split_m ? flen_w : nbytes_w;
        acc_last    <= !split_m;
        sec_addr_r  <= addr_w + 64'(flen_w);
        sec_bytes_r <= 5'(nbytes_w - flen_w);
      end else if (done_w && st_r == EAG_ST_FIRST && !acc_last) begin
        acc_addr  <= sec_addr_r;
        acc_bytes <= sec_bytes_r;
        acc_last  <= 1'b1;
      end else if (done_w) begin
        acc_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  property p_no_stack_index;
    @(posedge clk_sys) disable iff (sys_rst)
      (take_w && index_en && index_sel == `EAG_REG_STACK_PTR && !ipr_w && !req_is_io)
      |=> (eff_addr == trunc_as($past(base_x) + $past(disp_x), $past(addr_size)));
  endproperty
  a_no_stack_index: assert property (p_no_stack_index) else $error("stack pointer used as index");

  property p_stack_seg;
    @(posedge clk_sys) disable iff (sys_rst)
      (take_w && !seg_ovr_en && base_en && !ipr_w && base_sel == `EAG_REG_FRAME_BASE)
      |=> (acc_seg == `EAG_SEG_STACK);
  endproperty
  a_stack_seg: assert property (p_stack_seg) else $error("frame base did not pick stack segment");

  property p_dq_fault;
    @(posedge clk_sys) disable iff (sys_rst)
      (take_w && req_strict && !req_is_io && op_size == `EAG_SZ_DQWORD && addr_w[3:0] != 4'h0)
      |=> (general_protection_fault && !acc_valid);
  endproperty
  a_dq_fault: assert property (p_dq_fault) else $error("misaligned strict access not faulted");

  property p_split_two;
    @(posedge clk_sys) disable iff (sys_rst)
      (take_w && !fault_w && split_m) |=> (acc_valid && !acc_last);
  endproperty
  a_split_two: assert property (p_split_two) else $error("unaligned access not split");

  property p_aligned_one;
    @(posedge clk_sys) disable iff (sys_rst)
      (take_w && !req_is_io && op_size == `EAG_SZ_QWORD && addr_w[2:0] == 3'h0) |=> (acc_last && acc_bytes == 5'h08);
  endproperty
  a_aligned_one: assert property (p_aligned_one) else $error("aligned quadword split");

  property p_second_half;
    @(posedge clk_sys) disable iff (sys_rst)
      (done_w && !acc_last) |=> (acc_valid && acc_last && acc_addr == $past(acc_addr) + 64'($past(acc_bytes)));
  endproperty
  a_second_half: assert property (p_second_half) else $error("second bus cycle misplaced");

  property p_trunc32;
    @(posedge clk_sys) disable iff (sys_rst)
      (take_w && addr_size == `EAG_AS_32) |=> (eff_addr[63:32] == 32'h0);
  endproperty
  a_trunc32: assert property (p_trunc32) else $error("address not truncated");

  property p_ip_rel;
    @(posedge clk_sys) disable iff (sys_rst)
      (take_w && ipr_w && !req_is_io) |=> (eff_addr == $past(instr_pointer) + {{32{$past(disp[31])}}, $past(disp)});
  endproperty
  a_ip_rel: assert property (p_ip_rel) else $error("relative address wrong");

  property p_port;
    @(posedge clk_sys) disable iff (sys_rst)
      (take_w && req_is_io && !io_use_imm) |=> (acc_io && acc_addr == {48'h0, $past(port_index_reg)});
  endproperty
  a_port: assert property (p_port) else $error("port address wrong");
endmodule
`default_nettype wire

// ===== verilog/eag_map.svh
// eag_map.svh: offsets, encodings and field positions for the effective address generator
// assumes inclusion by eag_pkg, the design files of this block and its bench
`ifndef EAG_MAP_SVH
`define EAG_MAP_SVH

// operand size codes
`define EAG_SZ_BYTE  3'h0
`define EAG_SZ_WORD  3'h1
`define EAG_SZ_DWORD 3'h2
`define EAG_SZ_QWORD 3'h3
`define EAG_SZ_DQWORD 3'h4

// address size codes
`define EAG_AS_16 2'h0
`define EAG_AS_32 2'h1
`define EAG_AS_64 2'h2

// displacement width codes
`define EAG_DW_NONE 2'h0
`define EAG_DW_8    2'h1
`define EAG_DW_16   2'h2
`define EAG_DW_32   2'h3

// scale codes (log2 of factor); factor one only for index without scale
`define EAG_SC_1 2'h0
`define EAG_SC_2 2'h1
`define EAG_SC_4 2'h2
`define EAG_SC_8 2'h3

// register numbers with special meaning
`define EAG_REG_STACK_PTR  4'h4
`define EAG_REG_FRAME_BASE 4'h5

// segment codes
`define EAG_SEG_DATA  2'h0
`define EAG_SEG_STACK 2'h1
`define EAG_SEG_EXTRA 2'h2
`define EAG_SEG_CODE  2'h3

// bus chunk widths in bytes
`define EAG_CHUNK_SMALL 7'h04
`define EAG_CHUNK_QW    7'h08
`define EAG_CHUNK_DQ    7'h10

`endif

// ===== verilog/eag_pkg.sv
// eag_pkg.sv: types for the effective address generator
// assumes eag_map.svh on the include path
`include "eag_map.svh"
package eag_pkg;
  typedef logic [2:0] eag_size_t;
  typedef logic [1:0] eag_seg_t;
  typedef enum logic [2:0] {
    EAG_ST_IDLE  = 3'b001,
    EAG_ST_FIRST = 3'b010,
    EAG_ST_SECND = 3'b100
  } eag_state_t;
endpackage

// ===== verilog/eag_align.sv
// eag_align.sv: alignment check and split point for one access
// assumes address and size are stable while they are read
`timescale 1ns/1ps
`default_nettype none
`include "eag_map.svh"
module eag_align
  import eag_pkg::*;
(
  // access
  input  wire logic [3:0] addr_lo,
  input  wire eag_size_t  size,
  input  wire logic       strict,
  // result
  output logic            split,
  output logic            fault,
  output logic [4:0]      first_len
);
  // ==========================================================
  // byte count and boundary in force for this size
  wire [4:0] bytes_w = 5'(1) << size;
  wire [4:0] chunk_w = (size == `EAG_SZ_QWORD) ? 5'(`EAG_CHUNK_QW) :
                       (size == `EAG_SZ_DQWORD) ? 5'(`EAG_CHUNK_DQ) : 5'(`EAG_CHUNK_SMALL);
  wire [4:0] offs_w  = {1'b0, addr_lo} & (chunk_w - 5'(1));
  wire [5:0] end_w   = 6'(offs_w) + 6'(bytes_w);
  wire       cross_w = end_w > 6'(chunk_w);
  wire       dq_mis  = (size == `EAG_SZ_DQWORD) && (addr_lo != 4'h0);

  assign fault     = dq_mis && strict;
  assign split     = (size == `EAG_SZ_DQWORD) ? (dq_mis && !strict) : cross_w;
  assign first_len = 5'(chunk_w - offs_w);
endmodule
`default_nettype wire

// ===== tb/eag_acc_model.sv
// eag_acc_model.sv: access path model answering acc_valid with acc_ready
// assumes one clock; slow sets the wait before ready
`timescale 1ns/1ps
`default_nettype none
module eag_acc_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // access handshake
  input  wire logic       acc_valid,
  input  wire logic [1:0] slow,
  output logic            acc_ready
);
  // ==========
  // handshake
  logic [1:0] wait_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      acc_ready <= 1'b0;
      wait_r    <= 2'h0;
    end else if (acc_valid && !acc_ready && wait_r >= slow) begin
      acc_ready <= 1'b1;
      wait_r    <= 2'h0;
    end else begin
      acc_ready <= 1'b0;
      wait_r    <= (acc_valid && !acc_ready) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ===== tb/eag_top_tb.sv
// eag_top_tb.sv: self-checking bench for eag_top
// assumes eag_acc_model stands on the access path
`timescale 1ns/1ps
`default_nettype none
`include "eag_map.svh"
module eag_top_tb
  import eag_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid, req_is_io, req_ip_rel, req_strict, base_en, index_en, seg_ovr_en, io_use_imm;
  logic [1:0]  addr_size, scale, disp_width, slow;
  eag_size_t   op_size;
  eag_seg_t    seg_ovr, acc_seg;
  logic [3:0]  base_sel, index_sel;
  logic [31:0] disp;
  logic [7:0]  io_imm;
  logic [15:0] port_index_reg;
  logic [63:0] base_val, index_val, instr_pointer, seg_base, acc_addr, eff_addr;
  logic        acc_ready, busy, acc_valid, acc_io, acc_last, general_protection_fault, fl, dn;
  logic [4:0]  acc_bytes;
  logic [63:0] ga [2];
  logic [4:0]  gb [2];
  logic        gl [2];
  logic        gi [2];
  int          nacc, err_total, comparisons, cyc;
  // ==========
  // design and partner
  eag_top eag_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid), .req_is_io(req_is_io),
    .req_ip_rel(req_ip_rel), .req_strict(req_strict), .addr_size(addr_size), .op_size(op_size),
    .base_en(base_en), .base_sel(base_sel), .index_en(index_en), .index_sel(index_sel), .scale(scale),
    .disp_width(disp_width), .disp(disp), .seg_ovr_en(seg_ovr_en), .seg_ovr(seg_ovr),
    .io_use_imm(io_use_imm), .io_imm(io_imm), .base_val(base_val), .index_val(index_val),
    .instr_pointer(instr_pointer), .port_index_reg(port_index_reg), .seg_base(seg_base),
    .acc_ready(acc_ready), .busy(busy), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_bytes(acc_bytes),
    .acc_io(acc_io), .acc_last(acc_last), .acc_seg(acc_seg), .eff_addr(eff_addr),
    .general_protection_fault(general_protection_fault));
  eag_acc_model eag_acc_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .acc_valid(acc_valid), .slow(slow),
    .acc_ready(acc_ready));
  always #4 clk_sys = ~clk_sys;
  // ==========
  // shared tasks
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic clr();
    {req_valid, req_is_io, req_ip_rel, req_strict, base_en, index_en, seg_ovr_en, io_use_imm} <= 8'h00;
    {addr_size, scale, disp_width, op_size, seg_ovr, base_sel, index_sel, io_imm} <= 27'h0;
    {disp, port_index_reg} <= 48'h0;
    {base_val, index_val, instr_pointer, seg_base} <= 256'h0;
    @(posedge clk_sys);
  endtask
  // raise one request, then gather every handshake or the fault
  task automatic go();
    @(posedge clk_sys);
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    {nacc, fl, dn} = 0;
    for (int i = 0; i < 12 && !dn && !fl; i++) begin
      @(posedge clk_sys);
      fl = general_protection_fault === 1'b1;
      if (i == 0) chk("busy", 64'(!fl), 64'(busy));
      if (acc_valid === 1'b1 && acc_ready === 1'b1 && nacc < 2) begin
        {ga[nacc], gb[nacc], gl[nacc], gi[nacc]} = {acc_addr, acc_bytes, acc_last, acc_io};
        dn = acc_last === 1'b1;
        nacc++;
      end
    end
  endtask
  task automatic one(input logic [63:0] a, input logic [4:0] b, input logic io);
    chk("count", 64'h1, 64'(nacc));
    chk("addr", a, ga[0]);
    chk("bytes", 64'(b), 64'(gb[0]));
    chk("io", 64'(io), 64'(gi[0]));
  endtask
  // ==========
  // scenarios
  task automatic t_sib();
    logic [31:0] e;
    for (int s = 0; s < 4; s++) begin
      clr();
      {addr_size, op_size, disp_width, disp, scale} <= {`EAG_AS_32, `EAG_SZ_DWORD, `EAG_DW_8, 32'hF0, 2'(s)};
      {base_en, base_sel, index_en, index_sel} <= {1'b1, `EAG_REG_FRAME_BASE, 1'b1, 4'h3};
      {base_val, index_val, seg_base} <= {64'hABCD_0000_FFFF_FF00, 64'h40, 64'h1000};
      e = 32'hFFFF_FF00 + (32'h40 << s) - 32'h10;
      go();
      chk("eff_addr", {32'h0, e}, eff_addr);
      chk("seg", `EAG_SEG_STACK, acc_seg);
      one({32'h0, e} + 64'h1000, 5'h04, 1'b0);
    end
    $display("test sib done");
  endtask
  task automatic t_sp();
    clr();
    {addr_size, op_size, disp_width, disp, scale} <= {`EAG_AS_64, `EAG_SZ_QWORD, `EAG_DW_16, 32'h1234_8000, 2'h3};
    {base_en, base_sel, index_en, index_sel} <= {1'b1, `EAG_REG_STACK_PTR, 1'b1, `EAG_REG_STACK_PTR};
    {base_val, index_val, seg_base} <= {64'h0000_7FFF_0000_1000, 64'h100, 64'h1000};
    go();
    chk("eff_addr", 64'h0000_7FFE_FFFF_9000, eff_addr);
    chk("seg", `EAG_SEG_STACK, acc_seg);
    one(64'h0000_7FFE_FFFF_9000, 5'h08, 1'b0);
    clr();
    {addr_size, req_ip_rel, disp_width, disp} <= {`EAG_AS_64, 1'b1, `EAG_DW_32, 32'h8000_0000};
    {seg_ovr_en, seg_ovr, instr_pointer, seg_base} <= {1'b1, `EAG_SEG_EXTRA, 64'h1_2345_6780, 64'h1000};
    go();
    chk("eff_addr", 64'hA345_6780, eff_addr);
    chk("seg", `EAG_SEG_EXTRA, acc_seg);
    one(64'hA345_6780, 5'h01, 1'b0);
    clr();
    {addr_size, disp_width, disp, scale, index_val} <= {`EAG_AS_16, `EAG_DW_8, 32'hFFFF_FF03, 2'h3, 64'h10};
    {base_en, base_sel, base_val, seg_base} <= {1'b1, 4'h3, 64'hFFFF, 64'h20};
    go();
    chk("eff_addr", 64'h2, eff_addr);
    chk("seg", `EAG_SEG_DATA, acc_seg);
    one(64'h22, 5'h01, 1'b0);
    $display("test modes done");
  endtask
  task automatic t_io();
    clr();
    {req_is_io, io_use_imm, io_imm, op_size, port_index_reg} <= {2'h3, 8'h7F, `EAG_SZ_DWORD, 16'hFFFF};
    go();
    one(64'h7F, 5'h04, 1'b1);
    {io_use_imm, op_size} <= {1'b0, `EAG_SZ_WORD};
    go();
    one(64'hFFFF, 5'h02, 1'b1);
    $display("test io done");
  endtask
  task automatic t_align();
    int n, ch, off, f;
    logic [63:0] a;
    for (int sz = 0; sz < 5; sz++) begin
      for (int k = 0; k < 6; k++) begin
        a = 64'h1000 + 64'(3 * k + 1);
        n = 1 << sz;
        ch = sz < 3 ? 4 : (sz == 3 ? 8 : 16);
        off = int'(a[3:0]) % ch;
        f = (off + n > ch) ? ch - off : n;
        clr();
        {addr_size, op_size, base_en, base_val, slow} <= {`EAG_AS_64, 3'(sz), 1'b1, a, 2'(k % 3)};
        go();
        chk("count", 64'(f == n ? 1 : 2), 64'(nacc));
        chk("addr0", a, ga[0]);
        chk("bytes0", 64'(f), 64'(gb[0]));
        chk("last0", 64'(f == n), 64'(gl[0]));
        if (f != n) chk("addr1", a + 64'(f), ga[1]);
        if (f != n) chk("bytes1", 64'(n - f), 64'(gb[1]));
      end
    end
    $display("test align done");
  endtask
  task automatic t_strict();
    for (int k = 0; k < 2; k++) begin
      clr();
      {addr_size, op_size, req_strict, base_en, base_val} <= {`EAG_AS_64, `EAG_SZ_DQWORD, 2'h3, 64'h1008 + 64'(k * 8)};
      go();
      chk("fault", 64'(k == 0), 64'(fl));
      chk("count", 64'(k), 64'(nacc));
    end
    $display("test strict done");
  endtask
  initial begin
    slow <= 2'h0;
    clr();
    repeat (7) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_sib();
    t_sp();
    t_io();
    t_align();
    t_strict();
    conclude();
  end
endmodule
`default_nettype wire
